//--- usb_xfer_status.sv
// transfer status queue and descriptor table base registers on AHB-Lite
`timescale 1ns/100ps
`include "usb_xfer_status_params.svh"
module usb_xfer_status (
  input  wire logic        SYS_CLK,       // 250 MHz clock
  input  wire logic        RST_B,         // async reset, low
  input  wire logic        HSEL,          // slave select
  input  wire logic [31:0] HADDR,         // byte address
  input  wire logic [1:0]  HTRANS,        // transfer type
  input  wire logic        HWRITE,        // write not read
  input  wire logic [2:0]  HSIZE,         // transfer size
  input  wire logic [31:0] HWDATA,        // write data
  input  wire logic        HREADY,        // bus ready in
  output logic      [31:0] HRDATA,        // read data
  output logic             HREADYOUT,     // slave ready
  output logic             HRESP,         // always okay
  input  wire logic        XFER_DONE,     // engine: transfer completed pulse
  input  wire logic [3:0]  XFER_ENDPOINT, // engine: endpoint number
  input  wire logic        XFER_DIR_TX,   // engine: 1 transmit
  input  wire logic        XFER_BANK_ODD, // engine: 1 odd bank
  output logic             XFER_READY,    // queue has room
  output logic      [31:0] DESC_BASE_ADDR,// descriptor table base
  output logic             TRN_FLAG,      // transaction complete flag
  output logic             IRQ            // level interrupt
);

  localparam logic [2:0] DEPTH = `FIFO_DEPTH;

  // address phase capture
  logic        ph_valid;
  logic        ph_write;
  logic [11:0] ph_addr;

  // queue storage
  usb_xfer_status_pkg::xfer_entry_t mem [0:3];
  logic [`PTR_W-1:0] wr_ptr;
  logic [`PTR_W-1:0] rd_ptr;
  logic [2:0]        count;

  logic [7:0] base_page1;
  logic [7:0] base_page2;
  logic [7:0] base_page3;
  logic [`IRQ_W-1:0] irq_status;
  logic [`IRQ_W-1:0] irq_enable;

  logic push;
  logic pop;
  logic wr_clear;
  logic overflow;
  logic [`IRQ_W-1:0] clear_bits;
  logic [31:0] next_rdata;
  usb_xfer_status_pkg::xfer_entry_t head;

  // address phase accepted only on a NONSEQ or SEQ with hready
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr  <= 12'h000;
    end else if (HREADY) begin
      ph_valid <= HSEL && HTRANS[1];
      ph_write <= HWRITE;
      ph_addr  <= HADDR[11:0];
    end
  end

  assign wr_clear   = ph_valid && ph_write && (ph_addr == `OFS_IRQ_CLEAR);
  assign clear_bits = wr_clear ? HWDATA[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

  // writing one to the complete-flag clear bit pops one entry
  assign pop      = clear_bits[`IRQ_TRN_BIT] && (count != 3'h0);
  // queue full means the engine must hold its report; overflow still noted
  assign XFER_READY = (count != DEPTH) || pop;
  assign push     = XFER_DONE && XFER_READY;
  assign overflow = XFER_DONE && !XFER_READY;

  // queue storage write
  always_ff @(posedge SYS_CLK) begin
    if (push) begin
      mem[wr_ptr] <= '{XFER_ENDPOINT, XFER_DIR_TX, XFER_BANK_ODD};
    end
  end

  // queue pointers and occupancy
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= 3'h0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= 3'(count + {2'b00, push} - {2'b00, pop});
    end
  end

  assign head     = mem[rd_ptr];
  // flag follows occupancy, so it cannot clear while entries remain
  assign TRN_FLAG = (count != 3'h0);

  // base address bytes, written by software
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      base_page1 <= `RST_BYTE;
      base_page2 <= `RST_BYTE;
      base_page3 <= `RST_BYTE;
    end else if (ph_valid && ph_write) begin
      if (ph_addr == `OFS_DESC_BASE_PAGE1) begin
        base_page1 <= {HWDATA[7:1], 1'b0};
      end
      if (ph_addr == `OFS_DESC_BASE_PAGE2) begin
        base_page2 <= HWDATA[7:0];
      end
      if (ph_addr == `OFS_DESC_BASE_PAGE3) begin
        base_page3 <= HWDATA[7:0];
      end
    end
  end

  // low nine bits forced zero for alignment
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      DESC_BASE_ADDR <= 32'h00000000;
    end else begin
      DESC_BASE_ADDR <= {base_page3, base_page2, base_page1[7:1],
                         {`ALIGN_BITS{1'b0}}};
    end
  end

  // sticky events: set wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_status <= '0;
    end else begin
      irq_status[`IRQ_TRN_BIT] <= push ||
        (irq_status[`IRQ_TRN_BIT] && !clear_bits[`IRQ_TRN_BIT]);
      irq_status[`IRQ_OVF_BIT] <= overflow ||
        (irq_status[`IRQ_OVF_BIT] && !clear_bits[`IRQ_OVF_BIT]);
    end
  end

  // interrupt enable register
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_enable <= '0;
    end else if (ph_valid && ph_write && ph_addr == `OFS_IRQ_ENABLE) begin
      irq_enable <= HWDATA[`IRQ_W-1:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status & irq_enable);
    end
  end

  // read mux on the address phase; unused bits read zero
  always_comb begin
    next_rdata = 32'h00000000;
    case (HADDR[11:0])
      `OFS_XFER_STATUS: begin
        // empty queue reads zero rather than stale data
        if (count != 3'h0) begin
          next_rdata[`EP_LSB+3:`EP_LSB] = head.endpoint;
          next_rdata[`DIR_BIT]          = head.dir_tx;
          next_rdata[`BANK_BIT]         = head.bank_odd;
        end
      end
      `OFS_DESC_BASE_PAGE1: next_rdata[7:0] = base_page1;
      `OFS_DESC_BASE_PAGE2: next_rdata[7:0] = base_page2;
      `OFS_DESC_BASE_PAGE3: next_rdata[7:0] = base_page3;
      `OFS_IRQ_STATUS:      next_rdata[`IRQ_W-1:0] = irq_status;
      `OFS_IRQ_ENABLE:      next_rdata[`IRQ_W-1:0] = irq_enable;
      `OFS_INFO:            next_rdata[2:0] = count;
      default:              next_rdata = 32'h00000000;
    endcase
  end

  // read data registered into the data phase
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      HRDATA <= 32'h00000000;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      HRDATA <= next_rdata;
    end
  end

  // zero wait states, always okay
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

endmodule : usb_xfer_status

//--- usb_xfer_status_params.svh
// offsets, field positions and reset values for the transfer status block
`ifndef USB_XFER_STATUS_PARAMS_SVH
`define USB_XFER_STATUS_PARAMS_SVH
`define OFS_XFER_STATUS      12'h000
`define OFS_DESC_BASE_PAGE2 12'h004
`define OFS_DESC_BASE_PAGE3 12'h008
`define OFS_DESC_BASE_PAGE1 12'h00C
`define OFS_IRQ_STATUS      12'h010
`define OFS_IRQ_CLEAR       12'h014
`define OFS_IRQ_ENABLE      12'h018
`define OFS_INFO            12'h01C
`define FIFO_DEPTH          3'h4
`define PTR_W               2
`define EP_LSB              4
`define DIR_BIT             3
`define BANK_BIT            2
`define IRQ_TRN_BIT         0
`define IRQ_OVF_BIT         1
`define IRQ_W               2
`define ALIGN_BITS          9
`define RST_BYTE            8'h00
`endif

//--- usb_xfer_status_pkg.sv
// types for the transfer status block
package usb_xfer_status_pkg;
  typedef enum logic [1:0] {HTRANS_IDLE, HTRANS_BUSY, HTRANS_NONSEQ, HTRANS_SEQ} htrans_t;
  typedef struct packed {
    logic [3:0] endpoint;
    logic       dir_tx;
    logic       bank_odd;
  } xfer_entry_t;
endpackage : usb_xfer_status_pkg

//--- usb_xfer_status_props.sv
// concurrent checks on the transfer status block ports
`timescale 1ns/100ps
module usb_xfer_status_props (
  input wire logic        SYS_CLK,        // clock
  input wire logic        RST_B,          // reset, low
  input wire logic [31:0] HADDR,          // address
  input wire logic        HWRITE,         // write
  input wire logic [31:0] HRDATA,         // read data
  input wire logic        HREADYOUT,      // ready
  input wire logic        HRESP,          // response
  input wire logic        XFER_DONE,      // engine push
  input wire logic        XFER_READY,     // queue room
  input wire logic [31:0] DESC_BASE_ADDR, // table base
  input wire logic        TRN_FLAG        // complete flag
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // a push is one accepted engine pulse
  sequence s_push; XFER_DONE && XFER_READY; endsequence
  property p_push; s_push |=> TRN_FLAG; endproperty
  property p_rise; $rose(TRN_FLAG) |-> $past(XFER_DONE); endproperty
  property p_full; !XFER_READY |-> TRN_FLAG; endproperty
  // a pop needs a write whose address phase was two edges back
  property p_fall; $fell(TRN_FLAG) |-> $past(HWRITE, 2) && $past(HADDR[11:0], 2) == 12'h014;
  endproperty
  property p_base; $changed(DESC_BASE_ADDR) |-> $past(HWRITE, 2); endproperty
  property p_align; DESC_BASE_ADDR[8:0] == 9'h000; endproperty
  property p_high; HRDATA[31:8] == 24'h000000; endproperty
  property p_okay; HREADYOUT && !HRESP; endproperty
  a_push: assert property (p_push) else $error("flag low after push");
  a_rise: assert property (p_rise) else $error("flag rose without push");
  a_full: assert property (p_full) else $error("full while empty");
  a_fall: assert property (p_fall) else $error("pop without clear write");
  a_base: assert property (p_base) else $error("base moved without write");
  a_align: assert property (p_align) else $error("base not aligned");
  a_high: assert property (p_high) else $error("upper read bits set");
  a_okay: assert property (p_okay) else $error("bus not okay");
endmodule : usb_xfer_status_props
bind usb_xfer_status usb_xfer_status_props props (.SYS_CLK, .RST_B, .HADDR, .HWRITE,
  .HRDATA, .HREADYOUT, .HRESP, .XFER_DONE, .XFER_READY, .DESC_BASE_ADDR, .TRN_FLAG);

//--- usb_engine_model.sv
// packet engine model that reports completed transfers
`timescale 1ns/100ps
module usb_engine_model (
  input  wire logic clk,  // bus clock
  output logic      done, // transfer completed
  output logic [3:0] ep,  // endpoint
  output logic      tx,   // direction
  output logic      odd   // bank
);
  initial {done, ep, tx, odd} = 7'h00;
  // fields only qualify the pulse, so scramble them outside it
  task automatic push(input logic [5:0] e);
    @(posedge clk);
    {done, ep, tx, odd} <= {1'b1, e};
    @(posedge clk);
    {done, ep, tx, odd} <= {1'b0, ~e};
  endtask : push
endmodule : usb_engine_model

//--- usb_xfer_status_tb.sv
// self-checking bench for the transfer status block
`timescale 1ns/100ps
module usb_xfer_status_tb;
  logic SYS_CLK, RST_B, HSEL, HWRITE, HREADYOUT, HRESP, XFER_DONE, XFER_DIR_TX;
  logic XFER_BANK_ODD, XFER_READY, TRN_FLAG, IRQ;
  logic [31:0] HADDR, HWDATA, HRDATA, DESC_BASE_ADDR;
  logic [3:0]  XFER_ENDPOINT;
  logic [2:0]  HSIZE;
  logic [1:0]  HTRANS;
  int fails = 0, samples_checked = 0;
  usb_xfer_status dut (.SYS_CLK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .XFER_DONE, .XFER_ENDPOINT,
    .XFER_DIR_TX, .XFER_BANK_ODD, .XFER_READY, .DESC_BASE_ADDR, .TRN_FLAG, .IRQ);
  usb_engine_model eng (.clk(SYS_CLK), .done(XFER_DONE), .ep(XFER_ENDPOINT),
    .tx(XFER_DIR_TX), .odd(XFER_BANK_ODD));
  always #2 SYS_CLK = ~SYS_CLK;
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // single word transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    HSEL <= 1'b1; HTRANS <= 2'h2; HWRITE <= w; HADDR <= {20'h00000, a};
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0; HWDATA <= d;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd
  task automatic t_reset;
    chk(XFER_READY, 32'h1);
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h0);
    rd(12'h020, 32'h0);
  endtask : t_reset
  // unimplemented upper bits written as ones must read back zero
  task automatic t_base;
    wr(12'h004, 32'hFFFF_FFA5);
    wr(12'h008, 32'h0000_013C);
    wr(12'h00C, 32'h0000_00FF);
    rd(12'h004, 32'h0000_00A5);
    rd(12'h008, 32'h0000_003C);
    rd(12'h00C, 32'h0000_00FE);
    chk(DESC_BASE_ADDR, 32'h3CA5_FE00);
  endtask : t_base
  // fill past depth, then pop every entry in order
  task automatic t_queue;
    logic [5:0] e [5] = '{6'h00, 6'h3F, 6'h16, 6'h29, 6'h3D};
    wr(12'h018, 32'h1);
    for (int i = 0; i < 5; i++) eng.push(e[i]);
    #1 chk(XFER_READY, 32'h0);
    chk(IRQ, 32'h1);
    rd(12'h010, 32'h3);
    rd(12'h018, 32'h1);
    for (int i = 0; i < 4; i++) begin
      rd(12'h000, {24'h0, e[i], 2'h0});
      wr(12'h014, 32'h1);
    end
    rd(12'h01C, 32'h0);
    rd(12'h000, 32'h0);
    chk(TRN_FLAG, 32'h0);
    chk(IRQ, 32'h0);
  endtask : t_queue
  initial begin
    SYS_CLK = 0; RST_B = 0; HSEL = 0; HADDR = 0; HTRANS = 0;
    HWRITE = 0; HSIZE = 3'h2; HWDATA = 0;
    repeat (20) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    @(posedge SYS_CLK);
    t_reset;
    t_base;
    t_queue;
    end_of_test;
  end
  // a hang counts against the run
  initial begin
    #20000;
    fails++;
    end_of_test;
  end
endmodule : usb_xfer_status_tb
